/* rtl/ssa_pkg.sv */
// shared constants and types of the stereo serial audio link
// assumes a 25 MHz system clock on both ends of the link
package ssa_pkg;

	// ------------------------------------------------------------
	// framing
	// ------------------------------------------------------------
	localparam int SSA_SAMPLE_BITS = 24;
	localparam logic [4:0] SSA_LAST_BIT_IDX = 5'h17;
	localparam logic [4:0] SSA_PAD_BIT_IDX = 5'h18;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int SSA_CLK_PERIOD_NS = 40;
	localparam int SSA_BCLK_PERIOD_NS = 320;
	localparam logic [1:0] SSA_BCLK_HALF_LAST = 2'(SSA_BCLK_PERIOD_NS / (2 * SSA_CLK_PERIOD_NS) - 1);
	localparam logic [20:0] SSA_MUTE_RAMP_CYCLES = 21'h1fff80;
	localparam logic [15:0] SSA_WAKE_DELAY_CYCLES = 16'h8000;
	localparam logic [13:0] SSA_SILENCE_WORDS = 14'h2000;

	// ------------------------------------------------------------
	// controller registers, byte addresses
	// ------------------------------------------------------------
	localparam logic [11:0] SSA_REG_CTRL = 12'h000;
	localparam logic [11:0] SSA_REG_LEFT = 12'h004;
	localparam logic [11:0] SSA_REG_RIGHT = 12'h008;
	localparam logic [11:0] SSA_REG_STATUS = 12'h00c;
	localparam logic [11:0] SSA_REG_INT_EN = 12'h010;
	localparam logic [11:0] SSA_REG_INT_CLR = 12'h014;
	localparam logic [11:0] SSA_REG_LINK = 12'h018;
	localparam int SSA_CTRL_FMT_BIT = 0;
	localparam int SSA_CTRL_MUTEN_BIT = 1;
	localparam logic [1:0] SSA_CTRL_RESET = 2'h0;
	localparam int SSA_EV_FRAME = 0;
	localparam int SSA_EV_SIL_RISE = 1;
	localparam int SSA_EV_SIL_FALL = 2;
	localparam int SSA_EV_BITS = 3;

	// ------------------------------------------------------------
	// mute sequencer
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		SSA_STANDBY = 3'b000,
		SSA_WAKE = 3'b001,
		SSA_RAMP_UP = 3'b010,
		SSA_PLAY = 3'b011,
		SSA_RAMP_DOWN = 3'b100
	} ssa_mute_state_t;

endpackage : ssa_pkg

/* rtl/ssa_link_if.sv */
// three-wire serial audio link plus its control and status pins
// assumes both ends sample it with their own system clock
interface ssa_link_if;
	logic serialBitClock;
	logic channelWordClock;
	logic serialAudioIn;
	logic formatSelect;
	logic muteN;
	logic silenceFlag;

	modport device (
		input serialBitClock,
		input channelWordClock,
		input serialAudioIn,
		input formatSelect,
		input muteN,
		output silenceFlag
	);

	modport source (
		output serialBitClock,
		output channelWordClock,
		output serialAudioIn,
		output formatSelect,
		output muteN,
		input silenceFlag
	);
endinterface : ssa_link_if

/* rtl/ssa_sync.sv */
// two-flop synchroniser with rising-edge pulse
// assumes inputs are asynchronous to clk
module ssa_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [WIDTH-1:0] async,
	output logic [WIDTH-1:0] level,
	output logic [WIDTH-1:0] rise
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
		logic [WIDTH-1:0] last;
	} ssa_sync_state_t;

	ssa_sync_state_t st;
	ssa_sync_state_t next_st;

	// first stage is read only by the second
	always_comb begin
		next_st.meta = async;
		next_st.stable = st.meta;
		next_st.last = st.stable;
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign level = st.stable;
	assign rise = st.stable & ~st.last;
endmodule : ssa_sync

/* rtl/ssa_receiver.sv */
// audio-converter end of the link: serial decoder, silence flag, soft mute
// assumes clk is the master clock and the source drives the link pins
// Notes on behaviour
// (R01) decoder is timed by the serial bit clock
// (R02) words become 24-bit signed, zero padded
// (R03) format low standard, high left-justified
// (R04) flag after 8192 silent word periods
// (R05) async master clock above 192 fs
// (R06) sync master clock 128fs to 1152fs
// (R07) 256fs or more recommended up to 96k
// (R08) mute ramps volume down over 2097024 cycles
// (R09) silent ramp end enters analog-off standby
// (R10) release leaves standby, starts counter, analog on
// (R11) after 32768 cycles ramp up 2097024 cycles
// (R12) mute pin active low
// (R13) controller holds mute at power-up
// (R14) data and word clock taken on rising edges
// (R15) nonzero sample clears flag and count
// (R16) msb delay and left polarity per format
//
// The APB register port and the register offsets were chosen for this implementation.
module ssa_receiver
	import ssa_pkg::*;
#(
	parameter logic [20:0] MUTE_RAMP_CYCLES = SSA_MUTE_RAMP_CYCLES,
	parameter logic [15:0] WAKE_DELAY_CYCLES = SSA_WAKE_DELAY_CYCLES,
	parameter logic [13:0] SILENCE_WORDS = SSA_SILENCE_WORDS
) (
	input wire logic clk,
	input wire logic rstn,
	ssa_link_if.device link,
	output logic [23:0] leftSample,
	output logic [23:0] rightSample,
	output logic sampleValid,
	output logic [20:0] volumeLevel,
	output logic analogOn,
	output logic standby,
	output logic audioApplied
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		ssa_mute_state_t mstate;
		logic [20:0] rampCount;
		logic [15:0] wakeCount;
		logic prevWc;
		logic curLeftCh;
		logic [4:0] bitIdx;
		logic [23:0] shiftWord;
		logic [23:0] leftHold;
		logic [23:0] leftOut;
		logic [23:0] rightOut;
		logic valid;
		logic [13:0] silCount;
		logic silFlag;
	} ssa_rx_state_t;

	ssa_rx_state_t st;
	ssa_rx_state_t next_st;

	logic [4:0] pinLevel;
	logic [4:0] pinRise;
	logic bitRise;
	logic wcNow;
	logic sdNow;
	logic fmtLj;
	logic muteReq;
	logic wordStart;
	logic [23:0] doneWord;

	// ------------------------------------------------------------
	// pin capture
	// ------------------------------------------------------------
	// all pins share one delay, so data stays aligned with the clock edge
	ssa_sync #(
		.WIDTH(5)
	) u_pin_sync (
		.clk(clk),
		.rstn(rstn),
		.async({link.muteN, link.formatSelect, link.serialAudioIn, link.channelWordClock, link.serialBitClock}),
		.level(pinLevel),
		.rise(pinRise)
	);

	assign bitRise = pinRise[0]; // R01 R14
	assign wcNow = pinLevel[1];
	assign sdNow = pinLevel[2];
	assign fmtLj = pinLevel[3];
	assign muteReq = ~pinLevel[4]; // R12

	// place one bit below the bits already received; extra bits are dropped
	function automatic logic [23:0] ssa_insert_bit(
		input logic [23:0] word,
		input logic [4:0] idx,
		input logic b
	);
		logic [23:0] w;
		w = word;
		if (idx <= SSA_LAST_BIT_IDX) begin
			w[5'(SSA_LAST_BIT_IDX - idx)] = b; // R02
		end
		return w;
	endfunction : ssa_insert_bit

	// ------------------------------------------------------------
	// serial decoder and silence detect
	// ------------------------------------------------------------
	assign wordStart = wcNow != st.prevWc;
	// standard framing: the bit under the word clock change still closes the old word
	assign doneWord = fmtLj ? st.shiftWord : ssa_insert_bit(st.shiftWord, st.bitIdx, sdNow); // R16

	always_comb begin
		next_st = st;
		next_st.valid = 1'b0;
		if (bitRise) begin
			next_st.prevWc = wcNow;
			if (wordStart) begin
				if (st.curLeftCh) begin
					next_st.leftHold = doneWord;
				end else begin
					next_st.leftOut = st.leftHold;
					next_st.rightOut = doneWord;
					next_st.valid = 1'b1;
					if (st.leftHold == 24'h000000 && doneWord == 24'h000000) begin
						if (st.silCount != SILENCE_WORDS) begin
							next_st.silCount = 14'(st.silCount + 14'h0001);
						end
						next_st.silFlag = next_st.silCount == SILENCE_WORDS; // R04
					end else begin
						next_st.silCount = 14'h0000; // R15
						next_st.silFlag = 1'b0; // R15
					end
				end
				// R03 R16
				next_st.curLeftCh = fmtLj ? wcNow : ~wcNow;
				next_st.shiftWord = fmtLj ? ssa_insert_bit(24'h000000, 5'h00, sdNow) : 24'h000000;
				next_st.bitIdx = fmtLj ? 5'h01 : 5'h00;
			end else begin
				next_st.shiftWord = ssa_insert_bit(st.shiftWord, st.bitIdx, sdNow); // R02
				if (st.bitIdx != SSA_PAD_BIT_IDX) begin
					next_st.bitIdx = 5'(st.bitIdx + 5'h01);
				end
			end
		end

		// ------------------------------------------------------------
		// soft mute sequencer
		// ------------------------------------------------------------
		case (st.mstate)
			SSA_STANDBY: begin
				next_st.rampCount = 21'h000000;
				if (!muteReq) begin
					next_st.mstate = SSA_WAKE; // R10
					next_st.wakeCount = 16'h0000; // R10
				end
			end
			SSA_WAKE: begin
				if (muteReq) begin
					next_st.mstate = SSA_STANDBY;
				end else if (st.wakeCount == 16'(WAKE_DELAY_CYCLES - 16'h0001)) begin
					next_st.mstate = SSA_RAMP_UP; // R11
				end else begin
					next_st.wakeCount = 16'(st.wakeCount + 16'h0001);
				end
			end
			SSA_RAMP_UP: begin
				if (muteReq) begin
					next_st.mstate = SSA_RAMP_DOWN; // R08
				end else if (st.rampCount == MUTE_RAMP_CYCLES) begin
					next_st.mstate = SSA_PLAY;
				end else begin
					next_st.rampCount = 21'(st.rampCount + 21'h000001); // R11
				end
			end
			SSA_PLAY: begin
				if (muteReq) begin
					next_st.mstate = SSA_RAMP_DOWN; // R08
				end
			end
			SSA_RAMP_DOWN: begin
				// a release mid-ramp climbs back from the current level, no jump
				if (!muteReq) begin
					next_st.mstate = SSA_RAMP_UP;
				end else if (st.rampCount == 21'h000000) begin
					next_st.mstate = SSA_STANDBY; // R09
				end else begin
					next_st.rampCount = 21'(st.rampCount - 21'h000001); // R08
				end
			end
			default: begin
				next_st.mstate = SSA_STANDBY;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			st <= '0;
			st.mstate <= SSA_STANDBY;
		end else begin
			st <= next_st;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign leftSample = st.leftOut;
	assign rightSample = st.rightOut;
	assign sampleValid = st.valid;
	assign volumeLevel = st.rampCount;
	assign link.silenceFlag = st.silFlag; // R04
	assign standby = st.mstate == SSA_STANDBY; // R09
	assign analogOn = st.mstate != SSA_STANDBY; // R10
	assign audioApplied = st.mstate == SSA_RAMP_UP || st.mstate == SSA_PLAY || st.mstate == SSA_RAMP_DOWN; // R11

endmodule : ssa_receiver

/* rtl/ssa_source.sv */
// source and controller end: serial transmitter with APB registers
// assumes an APB master on the same clock; the far end samples the link
module ssa_source
	import ssa_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	ssa_link_if.source link,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [1:0] ctrl;
		logic [23:0] leftData;
		logic [23:0] rightData;
		logic [23:0] curLeft;
		logic [23:0] curRight;
		logic [SSA_EV_BITS-1:0] status;
		logic [SSA_EV_BITS-1:0] intEn;
		logic irq;
		logic [31:0] rdata;
		logic [1:0] divCnt;
		logic serial_bit_clock;
		logic [5:0] slot;
		logic wc;
		logic sd;
		logic silLast;
	} ssa_src_state_t;

	ssa_src_state_t st;
	ssa_src_state_t next_st;

	logic silLevel;
	logic silRise;
	logic [SSA_EV_BITS-1:0] events;
	logic [5:0] newSlot;
	logic [5:0] q;
	logic [23:0] chWord;
	logic wrAccess;

	function automatic logic ssa_reg_known(input logic [11:0] a);
		return a == SSA_REG_CTRL || a == SSA_REG_LEFT || a == SSA_REG_RIGHT || a == SSA_REG_STATUS
			|| a == SSA_REG_INT_EN || a == SSA_REG_INT_CLR || a == SSA_REG_LINK;
	endfunction : ssa_reg_known

	ssa_sync #(
		.WIDTH(1)
	) u_flag_sync (
		.clk(clk),
		.rstn(rstn),
		.async(link.silenceFlag),
		.level(silLevel),
		.rise(silRise)
	);

	// ------------------------------------------------------------
	// transmitter
	// ------------------------------------------------------------
	// changes happen on the falling bit clock, so the far end sees them settled at the rise
	assign newSlot = 6'(st.slot + 6'h01);
	assign q = st.ctrl[SSA_CTRL_FMT_BIT] ? newSlot : 6'(newSlot - 6'h01); // R16
	assign chWord = q[5] ? st.curRight : st.curLeft;
	assign wrAccess = psel && penable && pwrite;

	always_comb begin
		next_st = st;
		events = '0;
		events[SSA_EV_SIL_RISE] = silRise;
		events[SSA_EV_SIL_FALL] = st.silLast && !silLevel;
		next_st.silLast = silLevel;
		// 8 clk per bit, 512 clk per frame: a locked 512fs master clock
		if (st.divCnt == SSA_BCLK_HALF_LAST) begin
			next_st.divCnt = 2'h0;
			next_st.serial_bit_clock = ~st.serial_bit_clock; // R01 R05 R06 R07
			if (st.serial_bit_clock) begin
				next_st.slot = newSlot; // R14
				if (newSlot == 6'h00) begin
					next_st.curLeft = st.leftData;
					next_st.curRight = st.rightData;
					events[SSA_EV_FRAME] = 1'b1;
				end
				// word clock follows the slot itself, so in standard framing it leads the msb by one bit
				next_st.wc = st.ctrl[SSA_CTRL_FMT_BIT] ? ~newSlot[5] : newSlot[5]; // R16
				next_st.sd = q[4:0] <= SSA_LAST_BIT_IDX ? chWord[5'(SSA_LAST_BIT_IDX - q[4:0])] : 1'b0;
			end
		end else begin
			next_st.divCnt = 2'(st.divCnt + 2'h1);
		end

		// ------------------------------------------------------------
		// APB registers
		// ------------------------------------------------------------
		// read data is latched in setup so the access edge sees it stable
		if (psel && !penable) begin
			case (paddr)
				SSA_REG_CTRL: next_st.rdata = {30'h00000000, st.ctrl};
				SSA_REG_LEFT: next_st.rdata = {8'h00, st.leftData};
				SSA_REG_RIGHT: next_st.rdata = {8'h00, st.rightData};
				SSA_REG_STATUS: next_st.rdata = {29'h00000000, st.status};
				SSA_REG_INT_EN: next_st.rdata = {29'h00000000, st.intEn};
				SSA_REG_LINK: next_st.rdata = {31'h00000000, silLevel};
				default: next_st.rdata = 32'h00000000;
			endcase
		end
		if (wrAccess) begin
			case (paddr)
				SSA_REG_CTRL: next_st.ctrl = pwdata[1:0]; // R13
				SSA_REG_LEFT: next_st.leftData = pwdata[23:0];
				SSA_REG_RIGHT: next_st.rightData = pwdata[23:0];
				SSA_REG_INT_EN: next_st.intEn = pwdata[SSA_EV_BITS-1:0];
				default: begin
				end
			endcase
		end
		// a new event beats a clear in the same cycle
		if (wrAccess && paddr == SSA_REG_INT_CLR) begin
			next_st.status = (st.status & ~pwdata[SSA_EV_BITS-1:0]) | events;
		end else begin
			next_st.status = st.status | events;
		end
		next_st.irq = |(next_st.status & next_st.intEn);
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			st <= '0;
			st.ctrl <= SSA_CTRL_RESET; // R13
			st.slot <= 6'h3f;
		end else begin
			st <= next_st;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign pready = psel && penable;
	assign pslverr = psel && penable && (!ssa_reg_known(paddr) || (!pwrite && paddr == SSA_REG_INT_CLR));
	assign prdata = st.rdata;
	assign irq = st.irq;
	assign link.serialBitClock = st.serial_bit_clock;
	assign link.channelWordClock = st.wc;
	assign link.serialAudioIn = st.sd;
	assign link.formatSelect = st.ctrl[SSA_CTRL_FMT_BIT];
	assign link.muteN = st.ctrl[SSA_CTRL_MUTEN_BIT]; // R12

endmodule : ssa_source

/* tb/ssa_link_properties.sv */
// assertions on the serial audio link between the two ends
// assumes plain link signals, clk and synchronous active-low rstn
module ssa_link_properties #(
	parameter logic [13:0] SILENCE_WORDS = 14'h2000
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic serialBitClock,
	input wire logic channelWordClock,
	input wire logic serialAudioIn,
	input wire logic formatSelect,
	input wire logic muteN,
	input wire logic silenceFlag
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------
	// helpers
	// ----------------
	// a format change slips the frame, so framing checks wait it out
	localparam logic [23:0] QUIET_MIN = 24'((SILENCE_WORDS - 1) * 512);
	localparam logic [23:0] QUIET_DUE = 24'((SILENCE_WORDS + 2) * 512);
	logic wcPrev;
	logic fmtPrev;
	logic [8:0] wcCnt;
	logic [9:0] fmtAge;
	logic [23:0] quietCnt;
	logic newWord;
	assign newWord = (channelWordClock != wcPrev) && (fmtAge == 10'h3ff);
	always_ff @(posedge clk) begin
		if (!rstn) begin
			wcPrev <= 1'b0;
			fmtPrev <= 1'b0;
			wcCnt <= 9'h000;
			fmtAge <= 10'h000;
			quietCnt <= 24'h0;
		end else begin
			wcPrev <= channelWordClock;
			fmtPrev <= formatSelect;
			wcCnt <= (channelWordClock != wcPrev) ? 9'h001 : wcCnt + ((&wcCnt) ? 9'h000 : 9'h001);
			fmtAge <= (formatSelect != fmtPrev) ? 10'h000 : fmtAge + ((&fmtAge) ? 10'h000 : 10'h001);
			quietCnt <= serialAudioIn ? 24'h0 : quietCnt + ((&quietCnt) ? 24'h0 : 24'h1);
		end
	end
	// ----------------
	// properties
	// ----------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);
	chk_bck_high: assert property (
		$rose(serialBitClock) |-> serialBitClock [*4] ##1 !serialBitClock) else $error("bit clock high phase");
	chk_bck_low: assert property (
		$fell(serialBitClock) |-> !serialBitClock [*4] ##1 serialBitClock) else $error("bit clock low phase");
	chk_edge_stable: assert property (
		$rose(serialBitClock) |-> $stable(channelWordClock) && $stable(serialAudioIn)) else $error("moved at rise");
	chk_change_low: assert property (
		$changed(channelWordClock) || $changed(serialAudioIn) |-> !serialBitClock) else $error("moved while high");
	chk_word_period: assert property (
		newWord |-> wcCnt == 9'h100) else $error("word clock period");
	chk_word_pad: assert property (
		newWord |-> quietCnt >= 24'h30) else $error("word padding");
	chk_std_lead: assert property (
		newWord && !formatSelect |-> !serialAudioIn [*7]) else $error("msb not delayed");
	chk_silence_early: assert property (
		$rose(silenceFlag) |-> quietCnt >= QUIET_MIN) else $error("silence flag early");
	chk_silence_due: assert property (
		quietCnt == QUIET_DUE |-> silenceFlag) else $error("silence flag late");
	chk_silence_clear: assert property (
		$rose(serialAudioIn) && silenceFlag |-> ##[1:800] !silenceFlag) else $error("silence not cleared");
	chk_silence_hold: assert property (
		$fell(silenceFlag) |-> quietCnt < 24'h400) else $error("silence cleared on quiet");
endmodule : ssa_link_properties

/* tb/stereo_serial_audio_receiver_mute_bench.sv */
// bench joining source and receiver over the link, driving APB
// assumes short ramp, wake and silence counts set here
module stereo_serial_audio_receiver_mute_bench import ssa_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [20:0] RAMP = 21'h000040;
	localparam logic [15:0] WAKE = 16'h0010;
	localparam logic [13:0] SIL = 14'h0004;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, irq, sampleValid, analogOn, standby, audioApplied;
	logic [23:0] leftSample, rightSample, l, r;
	logic [20:0] volumeLevel;
	logic [63:0] smpQ[$], rdQ[$], tQ[$];
	int bad_count = 0;
	int n_checks = 0;
	int cycles = 0;
	int wakeN = 0;
	int rampN = 0;
	logic stbPrev = 1'b1;
	ssa_link_if link();
	ssa_source i_ssa_source(.clk(clk), .rstn(rstn), .link(link), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq));
	ssa_receiver #(.MUTE_RAMP_CYCLES(RAMP), .WAKE_DELAY_CYCLES(WAKE), .SILENCE_WORDS(SIL)) i_ssa_receiver(
		.clk(clk), .rstn(rstn), .link(link), .leftSample(leftSample), .rightSample(rightSample),
		.sampleValid(sampleValid), .volumeLevel(volumeLevel), .analogOn(analogOn), .standby(standby),
		.audioApplied(audioApplied));
	ssa_link_properties #(.SILENCE_WORDS(SIL)) i_ssa_link_properties(.clk(clk), .rstn(rstn),
		.serialBitClock(link.serialBitClock), .channelWordClock(link.channelWordClock),
		.serialAudioIn(link.serialAudioIn), .formatSelect(link.formatSelect), .muteN(link.muteN),
		.silenceFlag(link.silenceFlag));
	always #20 clk = ~clk;
	// ----------------
	// tasks
	// ----------------
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk iff pready);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb
	task automatic rd(input logic [11:0] a, input logic [63:0] e);
		rdQ.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask : rd
	task automatic close_out;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : close_out
	// ----------------
	// result watcher
	// ----------------
	always @(posedge clk) begin
		cycles++;
		if (cycles == 60000) begin
			bad_count++;
			$display("ERROR at %0t: timeout", $time);
			close_out();
		end
		if (sampleValid && smpQ.size() > 0)
			check({leftSample, rightSample}, smpQ.pop_front());
		if (psel && penable && pready && !pwrite && rdQ.size() > 0)
			check({irq, pslverr, prdata}, rdQ.pop_front());
		if (analogOn && !audioApplied)
			wakeN++;
		else if (wakeN > 0) begin
			check(64'(wakeN), tQ.pop_front());
			wakeN = 0;
		end
		if (volumeLevel != 21'h0 && volumeLevel != RAMP)
			rampN++;
		else if (rampN > 0) begin
			check(64'(rampN), tQ.pop_front());
			rampN = 0;
		end
		if (rstn && standby && !stbPrev)
			check({analogOn, audioApplied, volumeLevel}, tQ.pop_front());
		stbPrev = standby;
	end
	// ----------------
	// stimulus
	// ----------------
	// mute stays low through the data tests, so decoding is seen in standby
	initial begin
		void'($urandom(32'h516e));
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		check({standby, analogOn, link.silenceFlag}, 64'h4);
		rd(SSA_REG_CTRL, 64'h0);
		rd(12'h01c, 64'h100000000);
		rd(SSA_REG_INT_CLR, 64'h100000000);
		rd(12'h006, 64'h100000000);
		$display("test registers done");
		for (int f = 0; f < 2; f++) begin
			apb(1'b1, SSA_REG_CTRL, 32'(f));
			for (int i = 0; i < 3; i++) begin
				l = (i == 0) ? 24'h800001 : 24'($urandom);
				r = (i == 0) ? 24'h000001 : 24'($urandom);
				apb(1'b1, SSA_REG_LEFT, {8'h0, l});
				apb(1'b1, SSA_REG_RIGHT, {8'h0, r});
				rd(SSA_REG_LEFT, {40'h0, l});
				repeat (3) @(posedge clk iff sampleValid);
				@(posedge clk);
				smpQ.push_back({16'h0, l, r});
				@(posedge clk iff smpQ.size() == 0);
			end
			$display("test format %0d done", f);
		end
		apb(1'b1, SSA_REG_LEFT, 32'h0);
		apb(1'b1, SSA_REG_RIGHT, 32'h0);
		apb(1'b1, SSA_REG_INT_CLR, 32'h7);
		apb(1'b1, SSA_REG_INT_EN, 32'h2);
		@(posedge clk iff link.silenceFlag);
		repeat (8) @(posedge clk);
		rd(SSA_REG_LINK, 64'h200000001);
		rd(SSA_REG_STATUS, 64'h200000003);
		apb(1'b1, SSA_REG_INT_EN, 32'h0);
		rd(SSA_REG_STATUS, 64'h3);
		apb(1'b1, SSA_REG_INT_EN, 32'h2);
		apb(1'b1, SSA_REG_INT_CLR, 32'h2);
		rd(SSA_REG_STATUS, 64'h1);
		l = 24'($urandom) | 24'h000001;
		apb(1'b1, SSA_REG_LEFT, {8'h0, l});
		@(posedge clk iff !link.silenceFlag);
		repeat (8) @(posedge clk);
		rd(SSA_REG_STATUS, 64'h5);
		rd(SSA_REG_LINK, 64'h0);
		$display("test silence done");
		tQ.push_back(64'(WAKE));
		tQ.push_back(64'(RAMP) - 64'h1);
		apb(1'b1, SSA_REG_CTRL, 32'h2);
		@(posedge clk iff volumeLevel == RAMP);
		repeat (4) @(posedge clk);
		tQ.push_back(64'(RAMP) - 64'h1);
		tQ.push_back(64'h0);
		apb(1'b1, SSA_REG_CTRL, 32'h0);
		@(posedge clk iff tQ.size() == 0);
		$display("test mute done");
		close_out();
	end
endmodule : stereo_serial_audio_receiver_mute_bench
